// [common/rpbm_defines.svh]
// register indices, reset values and field positions of the port monitor
`ifndef RPBM_DEFINES_SVH
`define RPBM_DEFINES_SVH

// register indices; byte address is four times the index
`define RPBM_IDX_BCG_SRC_LO   10'h06e
`define RPBM_IDX_BCG_SRC_HI   10'h06f
`define RPBM_IDX_RAW10_TAG    10'h070
`define RPBM_IDX_RAW12_TAG    10'h071
`define RPBM_IDX_LINES_HIGH   10'h073
`define RPBM_IDX_LINES_LOW    10'h074
`define RPBM_IDX_WIDTH_HIGH   10'h075
`define RPBM_IDX_WIDTH_LOW    10'h076
`define RPBM_IDX_IRQ_STATUS   10'h080
`define RPBM_IDX_IRQ_MASK     10'h081

// reset values
`define RPBM_RST_BCG_SRC      8'h88
`define RPBM_RST_SEL          4'h8
`define RPBM_RST_RAW10_DATA_TYPE     6'h2b
`define RPBM_RST_RAW12_DATA_TYPE     6'h2c

// selector encodings
`define RPBM_SEL_CONST0       4'h8
`define RPBM_SEL_CONST1       4'h9
`define RPBM_SEL_FSYNC        4'ha

// field positions
`define RPBM_VC_MSB           7
`define RPBM_VC_LSB           6
`define RPBM_DT_MSB           5
`define RPBM_DT_LSB           0

// interrupt bit positions, shared by status and mask
`define RPBM_IRQ_LINES        0
`define RPBM_IRQ_WIDTH        1
`define RPBM_IRQ_BITS         2

// monitor counter width and apb address width
`define RPBM_CNT_W            16
`define RPBM_ADDR_W           12

`endif

// [common/rpbm_pkg.sv]
// types shared by the receive port monitor block
`default_nettype none
`include "rpbm_defines.svh"

package rpbm_pkg;

  // video timing qualifiers from the receive datapath
  typedef struct packed {
    logic frame_valid;  // high for the whole frame
    logic line_valid;   // high during each active line
  } rpbm_video_t;

  // csi identifier stamped on raw video packets
  typedef struct packed {
    logic [1:0] vc;     // virtual channel
    logic [5:0] dt;     // data type
  } rpbm_csi_tag_t;

  // apb slave phase, gray coded along idle, access, done
  typedef enum logic [1:0] {
    RPBM_IDLE = 2'b00,
    RPBM_ACC  = 2'b01,
    RPBM_DONE = 2'b11
  } rpbm_apb_st_t;

endpackage : rpbm_pkg
`default_nettype wire

// [hdl/rpbm_regs.sv]
// receive port back channel source, csi tags and video monitor registers
`default_nettype none
`include "rpbm_defines.svh"

module rpbm_regs #(
  parameter int PORT_NUM = 0  // receive port number, 0 to 3
) (
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  input  wire logic [`RPBM_ADDR_W-1:0]       paddr,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [31:0]                   pwdata,
  input  wire logic [3:0]                    pstrb,
  output logic [31:0]                        prdata,
  output logic                               pready,
  output logic                               pslverr,
  input  wire rpbm_pkg::rpbm_video_t         video,
  input  wire logic                          frame_sync_pulse,
  input  wire logic [7:0]                    gpio_pin_in,
  output logic [3:0]                         backchan_gpio,
  output rpbm_pkg::rpbm_csi_tag_t            raw10_tag,
  output rpbm_pkg::rpbm_csi_tag_t            raw12_tag,
  output logic                               irq
);
  import rpbm_pkg::*;

  // the virtual channel field is only two bits wide
  if (PORT_NUM < 0 || PORT_NUM > 3) begin : g_bad_port
    $error("PORT_NUM must be 0 to 3");
  end

  localparam logic [1:0] PORT_VC = 2'(PORT_NUM);  // vc reset value

  // apb slave: one wait state so prdata and pready leave flip-flops
  rpbm_apb_st_t       apb_st_r;      // slave phase
  logic [31:0]        prdata_r;      // read data staged in first access
  logic               pslverr_r;     // unmapped address answer
  logic [9:0]         idx;           // word index of the access
  logic               hit;           // index names a register
  logic [7:0]         rd_val;        // byte read from the decoded reg
  logic               done;          // completing edge of a transfer
  logic               wr_done;       // write takes effect now
  logic               rd_done;       // read side effects happen now
  logic               rd_stage;      // read byte is taken this edge

  assign idx     = paddr[`RPBM_ADDR_W-1:2];
  assign done    = psel && penable && (apb_st_r == RPBM_DONE);
  // only byte lane 0 carries register data; others are ignored
  assign wr_done = done && pwrite && hit && pstrb[0];
  assign rd_done = done && !pwrite && hit;
  assign rd_stage = psel && penable && !pwrite && (apb_st_r == RPBM_ACC);

  // phase sequencing: idle, access (stage data), done (pready high)
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      apb_st_r <= RPBM_IDLE;
    end else begin
      case (apb_st_r)
        RPBM_IDLE: begin
          // setup seen; next edge is the first access cycle
          if (psel && !penable) begin
            apb_st_r <= RPBM_ACC;
          end
        end
        RPBM_ACC: begin
          if (psel && penable) begin
            apb_st_r <= RPBM_DONE;
          end
        end
        RPBM_DONE: begin
          apb_st_r <= RPBM_IDLE;
        end
        default: begin
          apb_st_r <= RPBM_IDLE;
        end
      endcase
    end
  end

  // read data and error staged while the master waits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r  <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else if (apb_st_r == RPBM_ACC && psel && penable) begin
      prdata_r  <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_val};
      pslverr_r <= !hit;
    end else if (apb_st_r == RPBM_DONE) begin
      // drop data after the transfer so stale bytes do not linger
      prdata_r  <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end
  end

  assign prdata  = prdata_r;
  assign pready  = apb_st_r[1];  // only the done code has bit 1 set
  assign pslverr = pslverr_r;

  // configuration registers
  logic [15:0]              bcg_src_r;   // four 4-bit source selectors
  logic [7:0]               raw10_r;     // vc and dt for raw10
  logic [7:0]               raw12_r;     // vc and dt for raw12
  logic [`RPBM_IRQ_BITS-1:0] irq_mask_r;  // also the freeze enables
  logic [`RPBM_IRQ_BITS-1:0] irq_stat_r;  // sticky change events

  // selector bytes, two selectors in each
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bcg_src_r <= {`RPBM_RST_BCG_SRC, `RPBM_RST_BCG_SRC};
    end else if (wr_done && idx == `RPBM_IDX_BCG_SRC_LO) begin
      bcg_src_r[7:0] <= pwdata[7:0];
    end else if (wr_done && idx == `RPBM_IDX_BCG_SRC_HI) begin
      bcg_src_r[15:8] <= pwdata[7:0];
    end
  end

  // raw10 identifier; vc comes up as this port's number
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      raw10_r <= {PORT_VC, `RPBM_RST_RAW10_DATA_TYPE};
    end else if (wr_done && idx == `RPBM_IDX_RAW10_TAG) begin
      raw10_r <= pwdata[7:0];
    end
  end

  // raw12 identifier, same layout as raw10
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      raw12_r <= {PORT_VC, `RPBM_RST_RAW12_DATA_TYPE};
    end else if (wr_done && idx == `RPBM_IDX_RAW12_TAG) begin
      raw12_r <= pwdata[7:0];
    end
  end

  // mask: bit 0 lines changed enable, bit 1 width changed enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask_r <= '0;
    end else if (wr_done && idx == `RPBM_IDX_IRQ_MASK) begin
      irq_mask_r <= pwdata[`RPBM_IRQ_BITS-1:0];
    end
  end

  // tags go out as registered fields
  assign raw10_tag.vc = raw10_r[`RPBM_VC_MSB:`RPBM_VC_LSB];
  assign raw10_tag.dt = raw10_r[`RPBM_DT_MSB:`RPBM_DT_LSB];
  assign raw12_tag.vc = raw12_r[`RPBM_VC_MSB:`RPBM_VC_LSB];
  assign raw12_tag.dt = raw12_r[`RPBM_DT_MSB:`RPBM_DT_LSB];

  // back channel sources
  logic [7:0] gpio_meta_r;  // first synchroniser stage, pins only
  logic [7:0] gpio_sync_r;  // second stage, safe to use
  logic [3:0] bc_r;         // registered back channel bits

  // pins are asynchronous to pclk
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gpio_meta_r <= 8'h00;
      gpio_sync_r <= 8'h00;
    end else begin
      gpio_meta_r <= gpio_pin_in;
      gpio_sync_r <= gpio_meta_r;
    end
  end

  // one source mux per back channel bit
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_bc
      logic [3:0] sel;  // this bit's selector
      assign sel = bcg_src_r[gi*4 +: 4];
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          bc_r[gi] <= 1'b0;  // reset selector means constant zero
        end else if (!sel[3]) begin
          bc_r[gi] <= gpio_sync_r[sel[2:0]];
        end else if (sel == `RPBM_SEL_CONST0) begin
          bc_r[gi] <= 1'b0;
        end else if (sel == `RPBM_SEL_CONST1) begin
          bc_r[gi] <= 1'b1;
        end else if (sel == `RPBM_SEL_FSYNC) begin
          bc_r[gi] <= frame_sync_pulse;
        end else begin
          // reserved codes: send a quiet zero rather than garbage
          bc_r[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  assign backchan_gpio = bc_r;

  // video monitors
  logic                  fv_d_r;       // frame valid, last cycle
  logic                  lv_d_r;       // line valid, last cycle
  logic [`RPBM_CNT_W-1:0] line_cnt_r;   // lines seen in this frame
  logic [`RPBM_CNT_W-1:0] len_cnt_r;    // cycles in the current line
  logic [`RPBM_CNT_W-1:0] last_len_r;   // length of last finished line
  logic                  frame_end;    // frame valid falling
  logic                  line_end;     // line valid falling
  logic [`RPBM_CNT_W-1:0] lines_r;      // reported line count
  logic [`RPBM_CNT_W-1:0] width_r;      // reported line length
  logic [7:0]            lines_lo_r;   // low byte caught on high read
  logic [7:0]            width_lo_r;   // low byte caught on high read
  logic                  lines_hold_r; // frozen until software reads
  logic                  width_hold_r; // frozen until software reads
  logic                  lines_upd;    // report takes a new count
  logic                  width_upd;    // report takes a new length
  logic                  rd_lines_hi;  // high byte of count read now
  logic                  rd_width_hi;  // high byte of length read now

  assign frame_end   = fv_d_r && !video.frame_valid;
  assign line_end    = lv_d_r && !video.line_valid;
  assign rd_lines_hi = rd_done && idx == `RPBM_IDX_LINES_HIGH;
  assign rd_width_hi = rd_done && idx == `RPBM_IDX_WIDTH_HIGH;
  // an update is blocked only while a freeze is in force
  assign lines_upd   = frame_end && !lines_hold_r;
  assign width_upd   = frame_end && !width_hold_r;

  // edge history of the qualifiers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fv_d_r <= 1'b0;
      lv_d_r <= 1'b0;
    end else begin
      fv_d_r <= video.frame_valid;
      lv_d_r <= video.line_valid;
    end
  end

  // count lines within the frame; saturates instead of wrapping
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_cnt_r <= '0;
    end else if (!video.frame_valid) begin
      line_cnt_r <= '0;
    end else if (line_end && line_cnt_r != '1) begin
      line_cnt_r <= line_cnt_r + 1'b1;
    end
  end

  // line length in pclk cycles, kept per finished line
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      len_cnt_r  <= '0;
      last_len_r <= '0;
    end else begin
      if (video.line_valid) begin
        if (len_cnt_r != '1) begin
          len_cnt_r <= len_cnt_r + 1'b1;
        end
      end else begin
        len_cnt_r <= '0;
      end
      // later lines overwrite earlier ones, so the last one stays
      if (line_end) begin
        last_len_r <= len_cnt_r;
      end
    end
  end

  // reported line count at frame end; a line ending together with
  // the frame is included
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lines_r <= '0;
    end else if (lines_upd) begin
      lines_r <= (line_end && line_cnt_r != '1) ?
                 line_cnt_r + 1'b1 : line_cnt_r;
    end
  end

  // reported line length at frame end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      width_r <= '0;
    end else if (width_upd) begin
      width_r <= line_end ? len_cnt_r : last_len_r;
    end
  end

  // freeze control: set by an update while enabled, cleared by the
  // completing high byte read; the two can meet in one cycle only
  // while the hold is clear, and then the set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lines_hold_r <= 1'b0;
    end else if (lines_upd && irq_mask_r[`RPBM_IRQ_LINES]) begin
      lines_hold_r <= 1'b1;
    end else if (rd_lines_hi || !irq_mask_r[`RPBM_IRQ_LINES]) begin
      lines_hold_r <= 1'b0;
    end
  end

  // same freeze scheme for the line length
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      width_hold_r <= 1'b0;
    end else if (width_upd && irq_mask_r[`RPBM_IRQ_WIDTH]) begin
      width_hold_r <= 1'b1;
    end else if (rd_width_hi || !irq_mask_r[`RPBM_IRQ_WIDTH]) begin
      width_hold_r <= 1'b0;
    end
  end

  // low bytes are caught when the high byte is read, so a torn pair
  // is impossible even if a frame ends between the two reads
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lines_lo_r <= 8'h00;
    end else if (rd_stage && idx == `RPBM_IDX_LINES_HIGH) begin
      lines_lo_r <= lines_r[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      width_lo_r <= 8'h00;
    end else if (rd_stage && idx == `RPBM_IDX_WIDTH_HIGH) begin
      width_lo_r <= width_r[7:0];
    end
  end

  // change events: set when a new report differs; set wins over
  // the write-one clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_r <= '0;
    end else begin
      for (int b = 0; b < `RPBM_IRQ_BITS; b++) begin
        if (wr_done && idx == `RPBM_IDX_IRQ_STATUS && pwdata[b]) begin
          irq_stat_r[b] <= 1'b0;
        end
      end
      if (lines_upd && lines_r != ((line_end && line_cnt_r != '1) ?
          line_cnt_r + 1'b1 : line_cnt_r)) begin
        irq_stat_r[`RPBM_IRQ_LINES] <= 1'b1;
      end
      if (width_upd && width_r != (line_end ? len_cnt_r : last_len_r))
      begin
        irq_stat_r[`RPBM_IRQ_WIDTH] <= 1'b1;
      end
    end
  end

  // level interrupt, registered so it leaves a flip-flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat_r & irq_mask_r);
    end
  end

  // read decode
  // unmapped indices answer zero with pslverr
  always_comb begin
    hit    = 1'b1;
    rd_val = 8'h00;
    case (idx)
      `RPBM_IDX_BCG_SRC_LO: rd_val = bcg_src_r[7:0];
      `RPBM_IDX_BCG_SRC_HI: rd_val = bcg_src_r[15:8];
      `RPBM_IDX_RAW10_TAG:  rd_val = raw10_r;
      `RPBM_IDX_RAW12_TAG:  rd_val = raw12_r;
      `RPBM_IDX_LINES_HIGH: rd_val = lines_r[15:8];
      `RPBM_IDX_LINES_LOW:  rd_val = lines_lo_r;
      `RPBM_IDX_WIDTH_HIGH: rd_val = width_r[15:8];
      `RPBM_IDX_WIDTH_LOW:  rd_val = width_lo_r;
      `RPBM_IDX_IRQ_STATUS: rd_val = {6'h00, irq_stat_r};
      `RPBM_IDX_IRQ_MASK:   rd_val = {6'h00, irq_mask_r};
      default: begin
        hit = 1'b0;
      end
    endcase
  end

endmodule : rpbm_regs
`default_nettype wire

// [bench/rpbm_regs_monitor.sv]
// bound checker for the receive port monitor register block
`default_nettype none
`include "rpbm_defines.svh"

module rpbm_regs_monitor #(
  parameter int PORT_NUM = 0  // port number, handed on by the bind
) (
  input wire logic                    pclk,
  input wire logic                    presetn,
  input wire logic [`RPBM_ADDR_W-1:0] paddr,
  input wire logic                    psel,
  input wire logic                    penable,
  input wire logic                    pwrite,
  input wire logic [31:0]             pwdata,
  input wire logic [3:0]              pstrb,
  input wire logic [31:0]             prdata,
  input wire logic                    pready,
  input wire logic                    pslverr,
  input wire rpbm_pkg::rpbm_video_t   video,
  input wire logic                    frame_sync_pulse,
  input wire logic [7:0]              gpio_pin_in,
  input wire logic [3:0]              backchan_gpio,
  input wire rpbm_pkg::rpbm_csi_tag_t raw10_tag,
  input wire rpbm_pkg::rpbm_csi_tag_t raw12_tag,
  input wire logic                    irq
);
  import rpbm_pkg::*;

  logic [7:0] sel_lo_r;  // shadow of low selector byte
  logic [7:0] sel_hi_r;  // shadow of high selector byte
  logic [7:0] t10_r;     // shadow of raw10 tag
  logic [7:0] t12_r;     // shadow of raw12 tag
  logic       wr_ok;     // completing write, low byte strobed
  logic [9:0] widx;      // word index of the transfer

  assign wr_ok = psel && penable && pready && pwrite && pstrb[0];
  assign widx  = paddr[11:2];

  // shadows move at the completing edge, same as the design
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_lo_r <= `RPBM_RST_BCG_SRC;
      sel_hi_r <= `RPBM_RST_BCG_SRC;
      t10_r    <= {PORT_NUM[1:0], `RPBM_RST_RAW10_DATA_TYPE};
      t12_r    <= {PORT_NUM[1:0], `RPBM_RST_RAW12_DATA_TYPE};
    end else if (wr_ok) begin
      if (widx == `RPBM_IDX_BCG_SRC_LO) sel_lo_r <= pwdata[7:0];
      if (widx == `RPBM_IDX_BCG_SRC_HI) sel_hi_r <= pwdata[7:0];
      if (widx == `RPBM_IDX_RAW10_TAG) t10_r <= pwdata[7:0];
      if (widx == `RPBM_IDX_RAW12_TAG) t12_r <= pwdata[7:0];
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // pins need three edges of sync, so demand four stable samples
  a_pin_follow: assert property (
    (!sel_lo_r[3] && $stable(sel_lo_r) && $stable(gpio_pin_in))[*4]
    |-> backchan_gpio[0] == gpio_pin_in[sel_lo_r[2:0]])
    else $error("back channel bit 0 not following its pin");
  a_const_zero: assert property (
    (sel_lo_r[3:0] == `RPBM_SEL_CONST0)[*3] |-> !backchan_gpio[0])
    else $error("back channel bit 0 not held low");
  a_const_one: assert property (
    (sel_lo_r[7:4] == `RPBM_SEL_CONST1)[*3] |-> backchan_gpio[1])
    else $error("back channel bit 1 not held high");
  a_fsync_route: assert property (
    (sel_hi_r[3:0] == `RPBM_SEL_FSYNC && $stable(frame_sync_pulse))[*3]
    |-> backchan_gpio[2] == frame_sync_pulse)
    else $error("back channel bit 2 not carrying frame sync");
  a_hi_default: assert property (
    (sel_hi_r[7:4] == `RPBM_RST_SEL)[*3] |-> !backchan_gpio[3])
    else $error("back channel bit 3 not low under default selector");
  a_reset_quiet: assert property (
    $rose(presetn) |-> (backchan_gpio == 4'h0)[*3])
    else $error("back channel active right after reset");
  a_raw10_tag: assert property (
    raw10_tag == t10_r)
    else $error("raw10 tag differs from programmed value");
  a_raw12_tag: assert property (
    raw12_tag == t12_r)
    else $error("raw12 tag differs from programmed value");

  // main scenarios reached
  c_fsync: cover property (
    sel_hi_r[3:0] == `RPBM_SEL_FSYNC && backchan_gpio[2]);
  c_unmapped: cover property (pready && pslverr);
  c_irq: cover property ($rose(irq));
endmodule : rpbm_regs_monitor

bind rpbm_regs rpbm_regs_monitor #(.PORT_NUM(PORT_NUM)) u_mon (
  .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .video(video),
  .frame_sync_pulse(frame_sync_pulse), .gpio_pin_in(gpio_pin_in),
  .backchan_gpio(backchan_gpio), .raw10_tag(raw10_tag),
  .raw12_tag(raw12_tag), .irq(irq));
`default_nettype wire

// [bench/rpbm_far_model.sv]
// remote camera side: produces framed video for the receive port
`default_nettype none

module rpbm_far_model (
  input wire logic                  pclk,
  output var rpbm_pkg::rpbm_video_t video
);
  import rpbm_pkg::*;

  initial video = '0;

  // n lines of w cycles, last one wl cycles; two idle cycles between
  task automatic send_frame(input int n, input int w, input int wl);
    int len;
    @(posedge pclk);
    video.frame_valid <= 1'b1;
    for (int i = 0; i < n; i++) begin
      len = (i == n - 1) ? wl : w;
      repeat (2) @(posedge pclk);
      video.line_valid <= 1'b1;
      repeat (len) @(posedge pclk);
      video.line_valid <= 1'b0;
    end
    repeat (2) @(posedge pclk);
    video.frame_valid <= 1'b0;
    @(posedge pclk);
  endtask : send_frame
endmodule : rpbm_far_model
`default_nettype wire

// [bench/tb.sv]
// self-checking bench for the receive port monitor register block
`default_nettype none
`include "rpbm_defines.svh"

module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import rpbm_pkg::*;

  localparam logic [1:0] PN  = 2'h2;   // port number of this instance
  localparam logic [7:0] PAT = 8'h4d;  // pin pattern, not symmetric

  logic          pclk, presetn, psel, penable, pwrite, frame_sync_pulse;
  logic [11:0]   paddr;
  logic [31:0]   pwdata, prdata;
  logic [3:0]    pstrb, backchan_gpio;
  logic [7:0]    gpio_pin_in, rd_v;
  logic          pready, pslverr, irq, err_v;
  rpbm_video_t   video;
  rpbm_csi_tag_t raw10_tag, raw12_tag;
  int            error_cnt, n_tests;

  always #50 pclk = ~pclk;

  rpbm_far_model u_far (.pclk(pclk), .video(video));

  rpbm_regs #(.PORT_NUM(2)) dut (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .video(video),
    .frame_sync_pulse(frame_sync_pulse), .gpio_pin_in(gpio_pin_in),
    .backchan_gpio(backchan_gpio), .raw10_tag(raw10_tag),
    .raw12_tag(raw12_tag), .irq(irq));

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : close_out

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      error_cnt++;
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc

  // one apb transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [9:0] idx,
                     input logic [7:0] d, input logic [3:0] s);
    int k;
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= {idx, 2'b00};
    pwdata <= {24'h00_0000, d};
    pstrb  <= s;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    if (pready !== 1'b1) begin
      error_cnt++;
      close_out();
    end
    rd_v  = prdata[7:0];
    err_v = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d, 4'hf);
  endtask : wr

  task automatic rc(input logic [9:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00, 4'h0);
    chk(rd_v, exp);
  endtask : rc

  task automatic t_reset();
    rc(`RPBM_IDX_BCG_SRC_LO, `RPBM_RST_BCG_SRC);
    rc(`RPBM_IDX_BCG_SRC_HI, `RPBM_RST_BCG_SRC);
    rc(`RPBM_IDX_RAW10_TAG, {PN, `RPBM_RST_RAW10_DATA_TYPE});
    rc(`RPBM_IDX_RAW12_TAG, {PN, `RPBM_RST_RAW12_DATA_TYPE});
    rc(`RPBM_IDX_LINES_HIGH, 8'h00);
    rc(`RPBM_IDX_WIDTH_HIGH, 8'h00);
    chk(raw10_tag, {PN, `RPBM_RST_RAW10_DATA_TYPE});
    $display("test reset values done");
  endtask : t_reset

  // programmed tags, masked strobe, read-only and unmapped places
  task automatic t_tags();
    wr(`RPBM_IDX_RAW10_TAG, 8'h5a);
    rc(`RPBM_IDX_RAW10_TAG, 8'h5a);
    chk(raw10_tag, 8'h5a);
    wr(`RPBM_IDX_RAW12_TAG, 8'hc1);
    chk(raw12_tag, 8'hc1);
    apb(1'b1, `RPBM_IDX_RAW10_TAG, 8'h00, 4'h0);
    rc(`RPBM_IDX_RAW10_TAG, 8'h5a);
    wr(`RPBM_IDX_LINES_HIGH, 8'hff);
    rc(`RPBM_IDX_LINES_HIGH, 8'h00);
    apb(1'b0, 10'h3ff, 8'h00, 4'h0);
    chk({7'h00, err_v}, 8'h01);
    $display("test tags done");
  endtask : t_tags

  // every allowed selector code on all four back channel bits
  task automatic t_gpio();
    logic b;
    gpio_pin_in <= PAT;
    for (int c = 0; c < 11; c++) begin // reserved codes never written
      frame_sync_pulse <= (c == 10);
      wr(`RPBM_IDX_BCG_SRC_LO, {2{c[3:0]}});
      wr(`RPBM_IDX_BCG_SRC_HI, {2{c[3:0]}});
      cyc(4);
      b = (c < 8) ? PAT[c] : (c != 8);
      chk({4'h0, backchan_gpio}, {4'h0, {4{b}}});
    end
    frame_sync_pulse <= 1'b0;
    cyc(4);
    chk({4'h0, backchan_gpio}, 8'h00);
    $display("test back channel done");
  endtask : t_gpio

  // two-byte counts and the low byte latch on high reads
  task automatic t_lines();
    u_far.send_frame(259, 1, 300);
    cyc(2);
    rc(`RPBM_IDX_LINES_HIGH, 8'h01);
    rc(`RPBM_IDX_LINES_LOW, 8'h03);
    rc(`RPBM_IDX_WIDTH_HIGH, 8'h01);
    rc(`RPBM_IDX_WIDTH_LOW, 8'h2c);
    rc(`RPBM_IDX_LINES_HIGH, 8'h01);
    rc(`RPBM_IDX_WIDTH_HIGH, 8'h01);
    u_far.send_frame(2, 5, 5);
    cyc(2);
    rc(`RPBM_IDX_LINES_LOW, 8'h03);
    rc(`RPBM_IDX_WIDTH_LOW, 8'h2c);
    rc(`RPBM_IDX_LINES_HIGH, 8'h00);
    rc(`RPBM_IDX_LINES_LOW, 8'h02);
    rc(`RPBM_IDX_WIDTH_HIGH, 8'h00);
    rc(`RPBM_IDX_WIDTH_LOW, 8'h05);
    $display("test monitors done");
  endtask : t_lines

  // freeze while enabled, release on read, interrupt set, clear, mask
  task automatic t_freeze();
    wr(`RPBM_IDX_IRQ_STATUS, 8'h03);
    wr(`RPBM_IDX_IRQ_MASK, 8'h03);
    u_far.send_frame(4, 6, 6);
    u_far.send_frame(2, 9, 9);
    cyc(3);
    chk({7'h00, irq}, 8'h01);
    rc(`RPBM_IDX_LINES_HIGH, 8'h00);
    rc(`RPBM_IDX_LINES_LOW, 8'h04);
    rc(`RPBM_IDX_WIDTH_HIGH, 8'h00);
    rc(`RPBM_IDX_WIDTH_LOW, 8'h06);
    u_far.send_frame(2, 9, 9);
    cyc(2);
    rc(`RPBM_IDX_LINES_HIGH, 8'h00);
    rc(`RPBM_IDX_LINES_LOW, 8'h02);
    rc(`RPBM_IDX_WIDTH_HIGH, 8'h00);
    rc(`RPBM_IDX_WIDTH_LOW, 8'h09);
    wr(`RPBM_IDX_IRQ_STATUS, 8'h03);
    cyc(3);
    chk({7'h00, irq}, 8'h00);
    rc(`RPBM_IDX_IRQ_STATUS, 8'h00);
    wr(`RPBM_IDX_IRQ_MASK, 8'h00);
    u_far.send_frame(1, 3, 3);
    cyc(3);
    rc(`RPBM_IDX_IRQ_STATUS, 8'h03);
    chk({7'h00, irq}, 8'h00);
    rc(`RPBM_IDX_LINES_LOW, 8'h02);
    $display("test freeze done");
  endtask : t_freeze

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    pstrb = 4'h0;
    frame_sync_pulse = 1'b0;
    gpio_pin_in = 8'h00;
    error_cnt = 0;
    n_tests = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_tags();
    t_gpio();
    t_lines();
    t_freeze();
    close_out();
  end
endmodule : tb
`default_nettype wire
